// ===== core/tcp_pkg.sv
// Package: register map, field layout and constants of the timer/counter pin and clock setup core
// Assumes: 32-bit AHB-Lite register bus, 16 allocatable I/O lines
package tcp_pkg;
    // Register byte offsets
    localparam logic [7:0] TCP_CFG_OFS      = 8'h00;
    localparam logic [7:0] TCP_CLK_OFS      = 8'h04;
    localparam logic [7:0] TCP_MODE_OFS     = 8'h08;
    localparam logic [7:0] TCP_VAL_A_OFS    = 8'h0c;
    localparam logic [7:0] TCP_VAL_B_OFS    = 8'h10;
    localparam logic [7:0] TCP_CNT_A_OFS    = 8'h14;
    localparam logic [7:0] TCP_CNT_B_OFS    = 8'h18;
    localparam logic [7:0] TCP_STAT_OFS     = 8'h1c;
    localparam logic [7:0] TCP_MAP_OFS      = 8'h20;
    localparam logic [7:0] TCP_DIR_OFS      = 8'h24;
    // Config register fields
    localparam int TCP_CFG_NTMR_LSB  = 0;   // 2 bits: timer_count_select 0..2
    localparam int TCP_CFG_CEN_LSB   = 4;   // 2 bits: counter_enable_mask
    localparam int TCP_CFG_OFS_LSB   = 8;   // 4 bits: pin_base_offset
    localparam int TCP_CFG_SUP_BIT   = 12;  // Offset error suppression
    // Clock register fields
    localparam int TCP_CLK_SRC_LSB   = 0;   // 3 bits: clock_source_select
    localparam int TCP_CLK_DIV_LSB   = 8;   // 8 bits: clock_prescale
    // Mode register fields
    localparam int TCP_MODE_A_LSB    = 0;   // 4 bits
    localparam int TCP_MODE_B_LSB    = 8;   // 4 bits
    // Counter read-and-clear bit in counter register writes
    localparam int TCP_CNT_CLR_BIT   = 0;
    // Status bits (sticky, write one to clear)
    localparam int TCP_ST_OFS_ERR    = 0;
    localparam int TCP_ST_CA_ERR     = 1;
    localparam int TCP_ST_SRC_ERR    = 2;
    localparam int TCP_ST_MODE_ERR   = 3;
    // Reset values
    localparam logic [1:0] TCP_NTMR_RST  = 2'h0;
    localparam logic [1:0] TCP_CEN_RST   = 2'h0;
    localparam logic [3:0] TCP_OFS_RST   = 4'h4;
    localparam logic       TCP_SUP_RST   = 1'b0;
    localparam logic [2:0] TCP_SRC_RST   = 3'h2;
    localparam logic [7:0] TCP_DIV_RST   = 8'h01;
    localparam logic [3:0] TCP_MODE_RST  = 4'ha;
    // Offset limits and clock source boundary
    localparam logic [3:0] TCP_OFS_MIN   = 4'h4;
    localparam logic [3:0] TCP_OFS_MAX   = 4'h8;
    localparam logic [2:0] TCP_SRC_DIV0  = 3'h3;
    localparam logic [2:0] TCP_SRC_LAST  = 3'h6;
    localparam int TCP_LINES = 16;
    // Timer functions
    typedef enum logic [3:0] {
        TCP_FN_PWM16, TCP_FN_PWM8, TCP_FN_PER32_RISE, TCP_FN_PER32_FALL,
        TCP_FN_DUTY_IN, TCP_FN_CNT_IN, TCP_FN_CNT_DEB, TCP_FN_FREQ_OUT,
        TCP_FN_QUAD_IN, TCP_FN_STOP_IN, TCP_FN_SYS_LO, TCP_FN_SYS_HI,
        TCP_FN_PER16_RISE, TCP_FN_PER16_FALL, TCP_FN_LINE_IN, TCP_FN_BAD
    } tcp_fn_t;
    // Source frequencies in kHz at the current revision
    localparam int TCP_F0_KHZ = 4000;
    localparam int TCP_F1_KHZ = 12000;
    localparam int TCP_F2_KHZ = 48000;
    localparam int TCP_F3_KHZ = 1000;
endpackage

// ===== core/tcp_edge_counter.sv
// One 32-bit falling-edge accumulator with read-and-clear
// Assumes: line input already synchronised to hclk
`timescale 1ns/1ps
module tcp_edge_counter (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // Control
    input  wire logic        active,
    input  wire logic        clr,
    input  wire logic        line_s,
    // Count
    output logic [31:0]      count_r
);
    logic line_d_r;

    // Previous line level for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_d_r <= 1'b1;
        end else if (ce) begin
            line_d_r <= line_s;
        end
    end

    // Count falling edges only, clear restarts from zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= 32'h0000_0000;
        end else if (ce) begin
            if (clr) begin
                count_r <= 32'h0000_0000;
            end else if (active && line_d_r && !line_s) begin
                count_r <= count_r + 32'h0000_0001;
            end
        end
    end
endmodule // tcp_edge_counter

// ===== core/tcp_prescaler.sv
// Timer clock tick generator: seven sources, optional 8-bit divisor
// Assumes: hclk faster than twice the fastest source
`timescale 1ns/1ps
module tcp_prescaler #(
    parameter int CLK_KHZ = 200000,
    parameter bit OLD_REV = 1'b0
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // Selection
    input  wire logic [2:0]  src,
    input  wire logic [7:0]  div,
    // Tick out
    output logic             tick_r
);
    localparam int SHIFT = OLD_REV ? 1 : 0;
    logic [31:0] acc_r;
    logic [31:0] step;
    logic        base_tick;
    logic [8:0]  dcnt_r;
    logic [8:0]  dlim;

    // Base frequency step for a phase accumulator
    always_comb begin
        unique case (src)
            3'h0, 3'h4: step = 32'(TCP_STEP(tcp_pkg::TCP_F0_KHZ));
            3'h1, 3'h5: step = 32'(TCP_STEP(tcp_pkg::TCP_F1_KHZ));
            3'h3:       step = 32'(TCP_STEP(tcp_pkg::TCP_F3_KHZ));
            default:    step = 32'(TCP_STEP(tcp_pkg::TCP_F2_KHZ));
        endcase
    end

    function automatic longint TCP_STEP(input int f);
        TCP_STEP = ((longint'(f) >> SHIFT) << 32) / CLK_KHZ;
    endfunction

    // Divide by 256 for zero, else by the value
    assign dlim = (div == 8'h00) ? 9'h100 : {1'b0, div};

    // Phase accumulator gives the base source rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= 32'h0000_0000;
        end else if (ce) begin
            acc_r <= acc_r + step;
        end
    end
    assign base_tick = (acc_r + step) < acc_r;

    // Divided sources only; fixed sources bypass the divisor
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcnt_r <= 9'h000;
            tick_r <= 1'b0;
        end else if (ce) begin
            tick_r <= 1'b0;
            if (base_tick) begin
                if (src < tcp_pkg::TCP_SRC_DIV0) begin
                    tick_r <= 1'b1;
                    dcnt_r <= 9'h000;
                end else if (dcnt_r + 9'h001 >= dlim) begin
                    tick_r <= 1'b1;
                    dcnt_r <= 9'h000;
                end else begin
                    dcnt_r <= dcnt_r + 9'h001;
                end
            end
        end
    end
endmodule // tcp_prescaler

// ===== core/tcp_core.sv
// Timer/counter pin and clock setup core with AHB-Lite register slave
// Assumes: single AHB-Lite master, I/O lines asynchronous to hclk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Two mode-selectable timers and two edge counters, each enabled by configuration.
// - Enabled units take consecutive lines in order timer a, timer b, counter a, b.
// - Only offsets 4 to 8 accepted; 0 to 3 flags an error unless suppressed.
// - A requested offset of 0 to 3 acts as 4, with suppression on or off.
// - Only timers and counters move; all other line functions stay fixed.
// - Enabling a unit sets line direction; direction stays after disabling.
// - Function codes 0 to 7: PWM16, PWM8, period32 rise/fall, duty, counters, freq out.
// - Codes 8 to 14: quadrature, stop, system low (default), high, period16, line-to-line.
// - Timer-stop function allowed only on the odd timer.
// - One shared timer clock from seven sources, divided ones using the prescale.
// - Sources 0 to 2 ignore the prescale; only 3 to 6 are divided.
// - Prescale is 8 bits; zero divides by 256, others divide by themselves.
// - Earlier revision halves every source frequency, chosen at build time.
// - With a divided source, counter a is unavailable and claims no line.
// - Enabling counter a while a divided source is selected is rejected with error.
// - Selecting a divided source while counter a is enabled is rejected with error.
// - Each counter holds 32 bits and counts falling edges of its line.
// - Read-and-clear returns the count before the clear, then restarts at zero.
// - Counting is independent of timer clock source and prescale.
module tcp_core #(
    parameter int CLK_KHZ = 200000,
    parameter bit OLD_REV = 1'b0
) (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // I/O lines: flex 0..7 then extended 0..7
    input  wire logic [15:0] line_in,
    output logic [15:0]      line_claim,
    output logic [15:0]      line_out,
    output logic [15:0]      line_oe,
    // Shared timer clock tick
    output logic             timer_tick
);
    // Bus phase registers
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic [31:0] rdata_r;
    // Configuration
    logic [1:0]  ntmr_r;
    logic [1:0]  cen_r;
    logic [3:0]  ofs_r;
    logic        sup_r;
    logic [2:0]  src_r;
    logic [7:0]  div_r;
    logic [3:0]  mode_a_r;
    logic [3:0]  mode_b_r;
    logic [31:0] val_a_r;
    logic [31:0] val_b_r;
    logic [3:0]  stat_r;
    logic [3:0]  stat_set;
    // Line state
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;
    logic [15:0] claim_r;
    logic [15:0] dir_r;
    logic [15:0] out_r;
    logic [3:0]  unit_line [4];
    logic [3:0]  unit_on;
    logic        cnt_a_line_s;
    logic        cnt_b_line_s;
    logic [31:0] cnt_a;
    logic [31:0] cnt_b;
    logic        clr_a;
    logic        clr_b;
    logic        tick;
    logic [3:0]  eff_ofs;
    tcp_pkg::tcp_fn_t fn_a;
    tcp_pkg::tcp_fn_t fn_b;
    logic        wr_go;
    logic        divided;
    logic [31:0] wd;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture; zero wait state
    assign wr_go = wr_pend_r;
    assign wd    = hwdata;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else if (ce) begin
            wr_pend_r <= hsel && hready && htrans[1] && hwrite;
            rd_pend_r <= hsel && hready && htrans[1] && !hwrite;
            if (hsel && hready && htrans[1]) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // Fixed bus response: always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration writes with the counter a / divided source exclusion
    assign divided = src_r >= tcp_pkg::TCP_SRC_DIV0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ntmr_r   <= tcp_pkg::TCP_NTMR_RST;
            cen_r    <= tcp_pkg::TCP_CEN_RST;
            ofs_r    <= tcp_pkg::TCP_OFS_RST;
            sup_r    <= tcp_pkg::TCP_SUP_RST;
            src_r    <= tcp_pkg::TCP_SRC_RST;
            div_r    <= tcp_pkg::TCP_DIV_RST;
            mode_a_r <= tcp_pkg::TCP_MODE_RST;
            mode_b_r <= tcp_pkg::TCP_MODE_RST;
            val_a_r  <= 32'h0000_0000;
            val_b_r  <= 32'h0000_0000;
        end else if (ce && wr_go) begin
            unique case (addr_r)
                tcp_pkg::TCP_CFG_OFS: begin
                    ntmr_r <= (wd[tcp_pkg::TCP_CFG_NTMR_LSB +: 2] > 2'h2) ? 2'h2 : wd[tcp_pkg::TCP_CFG_NTMR_LSB +: 2];
                    // Counter a enable refused while a divided source runs
                    cen_r[0] <= wd[tcp_pkg::TCP_CFG_CEN_LSB] && !divided;
                    cen_r[1] <= wd[tcp_pkg::TCP_CFG_CEN_LSB + 1];
                    ofs_r  <= (wd[tcp_pkg::TCP_CFG_OFS_LSB +: 4] > tcp_pkg::TCP_OFS_MAX) ?
                              ofs_r : wd[tcp_pkg::TCP_CFG_OFS_LSB +: 4];
                    sup_r  <= wd[tcp_pkg::TCP_CFG_SUP_BIT];
                end
                tcp_pkg::TCP_CLK_OFS: begin
                    // Divided source refused while counter a is enabled
                    if (!(cen_r[0] && wd[tcp_pkg::TCP_CLK_SRC_LSB +: 3] >= tcp_pkg::TCP_SRC_DIV0)
                        && wd[tcp_pkg::TCP_CLK_SRC_LSB +: 3] <= tcp_pkg::TCP_SRC_LAST) begin
                        src_r <= wd[tcp_pkg::TCP_CLK_SRC_LSB +: 3];
                    end
                    div_r <= wd[tcp_pkg::TCP_CLK_DIV_LSB +: 8];
                end
                tcp_pkg::TCP_MODE_OFS: begin
                    if (wd[tcp_pkg::TCP_MODE_A_LSB +: 4] != 4'h9 && wd[tcp_pkg::TCP_MODE_A_LSB +: 4] != 4'hf) begin
                        mode_a_r <= wd[tcp_pkg::TCP_MODE_A_LSB +: 4];
                    end
                    if (wd[tcp_pkg::TCP_MODE_B_LSB +: 4] != 4'hf) begin
                        mode_b_r <= wd[tcp_pkg::TCP_MODE_B_LSB +: 4];
                    end
                end
                tcp_pkg::TCP_VAL_A_OFS: val_a_r <= wd;
                tcp_pkg::TCP_VAL_B_OFS: val_b_r <= wd;
                default: ;
            endcase
        end
    end

    // Error detection for the current write
    always_comb begin
        stat_set = 4'h0;
        if (wr_go && addr_r == tcp_pkg::TCP_CFG_OFS) begin
            if (wd[tcp_pkg::TCP_CFG_OFS_LSB +: 4] > tcp_pkg::TCP_OFS_MAX ||
                (wd[tcp_pkg::TCP_CFG_OFS_LSB +: 4] < tcp_pkg::TCP_OFS_MIN && !wd[tcp_pkg::TCP_CFG_SUP_BIT])) begin
                stat_set[tcp_pkg::TCP_ST_OFS_ERR] = 1'b1;
            end
            if (wd[tcp_pkg::TCP_CFG_CEN_LSB] && divided) begin
                stat_set[tcp_pkg::TCP_ST_CA_ERR] = 1'b1;
            end
        end
        if (wr_go && addr_r == tcp_pkg::TCP_CLK_OFS && cen_r[0] &&
            wd[tcp_pkg::TCP_CLK_SRC_LSB +: 3] >= tcp_pkg::TCP_SRC_DIV0) begin
            stat_set[tcp_pkg::TCP_ST_SRC_ERR] = 1'b1;
        end
        if (wr_go && addr_r == tcp_pkg::TCP_MODE_OFS &&
            (wd[tcp_pkg::TCP_MODE_A_LSB +: 4] == 4'h9 || wd[tcp_pkg::TCP_MODE_A_LSB +: 4] == 4'hf ||
             wd[tcp_pkg::TCP_MODE_B_LSB +: 4] == 4'hf)) begin
            stat_set[tcp_pkg::TCP_ST_MODE_ERR] = 1'b1;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= 4'h0;
        end else if (ce) begin
            if (wr_go && addr_r == tcp_pkg::TCP_STAT_OFS) begin
                stat_r <= (stat_r & ~wd[3:0]) | stat_set;
            end else begin
                stat_r <= stat_r | stat_set;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Function decode of each timer
    assign fn_a = tcp_pkg::tcp_fn_t'(mode_a_r);
    assign fn_b = tcp_pkg::tcp_fn_t'(mode_b_r);

    // Offsets below the minimum act as the lowest legal one, suppressed or not
    assign eff_ofs = (ofs_r < tcp_pkg::TCP_OFS_MIN) ? tcp_pkg::TCP_OFS_MIN : ofs_r;

    // Unit enables: counter a vanishes under a divided source
    assign unit_on = {cen_r[1], cen_r[0] && !divided, ntmr_r == 2'h2, ntmr_r != 2'h0};

    // Consecutive line allocation in fixed unit order
    always_comb begin
        logic [3:0] pos;
        pos = eff_ofs;
        for (int u = 0; u < 4; u++) begin
            unit_line[u] = pos;
            if (unit_on[u]) begin
                pos = pos + 4'h1;
            end
        end
    end

    // Line claim and direction; direction kept after disable
    for (genvar l = 0; l < tcp_pkg::TCP_LINES; l++) begin : g_line
        logic hit_a;
        logic hit_b;
        logic hit_c;
        assign hit_a = unit_on[0] && unit_line[0] == 4'(l);
        assign hit_b = unit_on[1] && unit_line[1] == 4'(l);
        assign hit_c = (unit_on[2] && unit_line[2] == 4'(l)) || (unit_on[3] && unit_line[3] == 4'(l));
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                claim_r[l] <= 1'b0;
                dir_r[l]   <= 1'b0;
                out_r[l]   <= 1'b0;
            end else if (ce) begin
                claim_r[l] <= hit_a || hit_b || hit_c;
                if (hit_a) begin
                    dir_r[l] <= fn_a == tcp_pkg::TCP_FN_PWM16 || fn_a == tcp_pkg::TCP_FN_PWM8 ||
                                fn_a == tcp_pkg::TCP_FN_FREQ_OUT;
                end else if (hit_b) begin
                    dir_r[l] <= fn_b == tcp_pkg::TCP_FN_PWM16 || fn_b == tcp_pkg::TCP_FN_PWM8 ||
                                fn_b == tcp_pkg::TCP_FN_FREQ_OUT;
                end else if (hit_c) begin
                    dir_r[l] <= 1'b0;
                end
                out_r[l] <= 1'b0;
            end
        end
    end

    // Two-flop synchronisers on the lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 16'hffff;
            sync2_r <= 16'hffff;
        end else if (ce) begin
            sync1_r <= line_in;
            sync2_r <= sync1_r;
        end
    end

    assign cnt_a_line_s = sync2_r[unit_line[2]];
    assign cnt_b_line_s = sync2_r[unit_line[3]];
    assign clr_a = wr_go && addr_r == tcp_pkg::TCP_CNT_A_OFS && wd[tcp_pkg::TCP_CNT_CLR_BIT];
    assign clr_b = wr_go && addr_r == tcp_pkg::TCP_CNT_B_OFS && wd[tcp_pkg::TCP_CNT_CLR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Counters and shared timer clock
    tcp_edge_counter u_cnt_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .active  (unit_on[2]),
        .clr     (clr_a),
        .line_s  (cnt_a_line_s),
        .count_r (cnt_a)
    );

    tcp_edge_counter u_cnt_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .active  (unit_on[3]),
        .clr     (clr_b),
        .line_s  (cnt_b_line_s),
        .count_r (cnt_b)
    );

    tcp_prescaler #(.CLK_KHZ(CLK_KHZ), .OLD_REV(OLD_REV)) u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .src     (src_r),
        .div     (div_r),
        .tick_r  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux registered; a clear write returns the prior count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce) begin
            if (hsel && hready && htrans[1]) begin
                unique case (haddr[7:0])
                    tcp_pkg::TCP_CFG_OFS:   rdata_r <= {19'h0, sup_r, ofs_r, 2'h0, cen_r, 2'h0, ntmr_r};
                    tcp_pkg::TCP_CLK_OFS:   rdata_r <= {16'h0, div_r, 5'h0, src_r};
                    tcp_pkg::TCP_MODE_OFS:  rdata_r <= {20'h0, mode_b_r, 4'h0, mode_a_r};
                    tcp_pkg::TCP_VAL_A_OFS: rdata_r <= val_a_r;
                    tcp_pkg::TCP_VAL_B_OFS: rdata_r <= val_b_r;
                    tcp_pkg::TCP_CNT_A_OFS: rdata_r <= cnt_a;
                    tcp_pkg::TCP_CNT_B_OFS: rdata_r <= cnt_b;
                    tcp_pkg::TCP_STAT_OFS:  rdata_r <= {28'h0, stat_r | stat_set};
                    tcp_pkg::TCP_MAP_OFS:   rdata_r <= {16'h0, claim_r};
                    tcp_pkg::TCP_DIR_OFS:   rdata_r <= {16'h0, dir_r};
                    default:                rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign hrdata = rdata_r;

    // Pin outputs registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_claim <= 16'h0000;
            line_out   <= 16'h0000;
            line_oe    <= 16'h0000;
            timer_tick <= 1'b0;
        end else if (ce) begin
            line_claim <= claim_r;
            line_out   <= out_r;
            line_oe    <= claim_r & dir_r;
            timer_tick <= tick;
        end
    end
endmodule // tcp_core

// ===== verification/tcp_core_properties.sv
// Concurrent checks on the ports of the timer/counter setup core
// Assumes: one hclk domain, bound to every tcp_core instance
`timescale 1ns/1ps
module tcp_core_properties (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Lines and tick
    input wire logic [15:0] line_claim,
    input wire logic [15:0] line_oe,
    input wire logic        timer_tick
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////////
    ready_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    low_lines_a: assert property (line_claim[3:0] == 4'h0) else $error("unit on low line");
    unit_count_a: assert property ($countones(line_claim) <= 4) else $error("too many lines");
    claim_run_a: assert property (((line_claim + (line_claim & (~line_claim + 16'h1))) & line_claim) == 16'h0)
        else $error("claimed lines not consecutive");
    oe_in_claim_a: assert property ((line_oe & ~line_claim) == 16'h0) else $error("unclaimed line driven");
    tick_pulse_a: assert property (timer_tick |=> !timer_tick) else $error("tick longer than a cycle");
    rdata_hold_a: assert property (!$past(hsel && hready && htrans[1]) |-> $stable(hrdata))
        else $error("read data moved");
    unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h27
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule // tcp_core_properties
bind tcp_core tcp_core_properties chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .line_claim(line_claim), .line_oe(line_oe), .timer_tick(timer_tick));

// ===== verification/tcp_line_model.sv
// External signal sources on the sixteen I/O lines
// Assumes: lines pulled up when nobody drives them
`timescale 1ns/1ps
module tcp_line_model (
    // Clock and device side
    input wire logic        hclk,
    input wire logic [15:0] line_out,
    input wire logic [15:0] line_oe,
    // Pin levels
    output logic [15:0]     line_in
);
    logic [15:0] ext_r;
    // Pull-ups hold idle lines high
    initial ext_r = 16'hffff;
    // Device output wins where it drives
    assign line_in = (ext_r & ~line_oe) | (line_out & line_oe);
    // Falling edges, each level held long enough to pass a synchroniser
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            repeat (4) @(posedge hclk);
            ext_r[idx] <= 1'b0;
            repeat (4) @(posedge hclk);
            ext_r[idx] <= 1'b1;
        end
    endtask
endmodule // tcp_line_model

// ===== verification/tb.sv
// Self-checking bench for the timer/counter setup core
// Assumes: zero-wait AHB-Lite slave, ce held high
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, timer_tick;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [15:0] line_in, line_claim, line_out, line_oe;
    int          mismatches, num_checks;
    tcp_core dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in), .line_claim(line_claim),
        .line_out(line_out), .line_oe(line_oe), .timer_tick(timer_tick));
    tcp_line_model line_u (.hclk(hclk), .line_out(line_out), .line_oe(line_oe), .line_in(line_in));
    ////////////////////////////////////////////////////////////////////////////////
    // One single transfer, read data left in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("register", e, q)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    function automatic logic [31:0] cfg(input int nt, input logic [1:0] cen, input int ofs, input logic sup);
        return {19'h0, sup, ofs[3:0], 2'h0, cen, 2'h0, nt[1:0]};
    endfunction
    // Expected lines: units in fixed order from the effective offset
    function automatic logic [15:0] alloc(input int nt, input logic [1:0] cen, input int ofs);
        int p = (ofs < 4) ? 4 : ofs;
        alloc = 16'h0;
        for (int i = 0; i < 4; i++) if (i < 2 ? i < nt : cen[i-2]) begin alloc[p] = 1'b1; p++; end
    endfunction
    task automatic ticks(input int n, input int e);
        int k = 0;
        repeat (n) begin @(posedge hclk); #1; k += timer_tick; end
        `CHK("ticks", 1'b1, k >= e - 1 && k <= e + 1)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_alloc;
        int nt[4] = '{1, 1, 2, 0};
        logic [1:0] cn[4] = '{2'h0, 2'h2, 2'h3, 2'h3};
        int of[4] = '{4, 6, 8, 2};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h00, cfg(nt[i], cn[i], of[i], 1'b0));
            wt(3);
            `CHK("claim", alloc(nt[i], cn[i], of[i]), line_claim)
        end
        rd(8'h1c, 32'h1);
        bus(1'b1, 8'h1c, 32'hf);
        bus(1'b1, 8'h00, cfg(0, 2'h3, 1, 1'b1));
        rd(8'h1c, 32'h0);
        `CHK("claim", alloc(0, 2'h3, 1), line_claim)
    endtask
    task automatic t_div;
        bus(1'b1, 8'h04, 32'h4);
        rd(8'h1c, 32'h4);
        rd(8'h04, 32'h2);
        bus(1'b1, 8'h00, cfg(0, 2'h2, 4, 1'b0));
        bus(1'b1, 8'h04, 32'h6);
        bus(1'b1, 8'h00, cfg(0, 2'h3, 4, 1'b0));
        rd(8'h1c, 32'h6);
        `CHK("claim", alloc(0, 2'h2, 4), line_claim)
        ticks(4000, 4);
        bus(1'b1, 8'h04, 32'h3006);
        ticks(2000, 10);
        bus(1'b1, 8'h04, 32'h3000);
        ticks(2000, 40);
    endtask
    task automatic t_count;
        bus(1'b1, 8'h04, 32'h102);
        bus(1'b1, 8'h1c, 32'hf);
        bus(1'b1, 8'h00, cfg(0, 2'h3, 4, 1'b0));
        wt(3);
        line_u.pulse(4, 3);
        line_u.pulse(5, 5);
        wt(8);
        rd(8'h14, 32'h3);
        bus(1'b1, 8'h14, 32'h1);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h5);
    endtask
    task automatic t_mode;
        logic [31:0] w;
        bus(1'b1, 8'h00, cfg(2, 2'h0, 4, 1'b0));
        bus(1'b1, 8'h08, 32'h9);
        rd(8'h1c, 32'h8);
        rd(8'h08, 32'h000a);
        for (int c = 0; c < 15; c++) begin
            w = (c << 8) | (c == 9 ? 0 : c);
            bus(1'b1, 8'h08, w);
            wt(3);
            rd(8'h08, w);
            `CHK("dir", {c inside {0, 1, 7}, w[3:0] inside {0, 1, 7}}, line_oe[5:4])
            `CHK("out", 16'h0000, line_out)
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge hclk);
        mismatches++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h00, 32'h400);
        rd(8'h04, 32'h102);
        rd(8'h08, 32'h0a0a);
        rd(8'h30, 32'h0);
        t_alloc;
        t_div;
        t_count;
        t_mode;
        tally_and_finish;
    end
endmodule // tb
